// >>> rtl/barrel_shifter.sv
`timescale 1ns/1ps
module barrel_shifter
  import flag_eval_pkg::*;
#(
  parameter int W = 32
)
(
  // operand
  input  wire logic [W-1:0]       data,
  input  wire shift_kind_t        kind,
  input  wire logic [SHAMT_W-1:0] amount,
  input  wire logic               carry_in,
  // shifted word
  output logic [W-1:0]            result,
  output logic                    carry_out
);

  localparam int AW = $clog2(W);

  logic [W:0]    wide;
  logic [AW-1:0] rot;

  // whole shift in one cycle, purely combinational
  always_comb
  begin
    wide      = '0;
    rot       = amount[AW-1:0];
    result    = data;
    carry_out = carry_in;
    case (kind)
      SHIFT_LEFT:
      begin
        wide   = {1'b0, data} << amount;
        result = wide[W-1:0];
        if (amount != 8'h00)
        begin
          carry_out = wide[W];
        end
      end
      SHIFT_RIGHT_LOGIC:
      begin
        wide   = {data, 1'b0} >> amount;
        result = wide[W:1];
        if (amount != 8'h00)
        begin
          carry_out = wide[0];
        end
      end
      SHIFT_RIGHT_ARITH:
      begin
        wide   = $signed({data, 1'b0}) >>> amount;
        result = wide[W:1];
        if (amount != 8'h00)
        begin
          carry_out = wide[0];
        end
      end
      SHIFT_ROTATE:
      begin
        result = (data >> rot) | (data << (W - rot));
        if (amount != 8'h00)
        begin
          carry_out = result[W-1];
        end
      end
      SHIFT_ROTATE_EXT:
      begin
        result    = {carry_in, data[W-1:1]};
        carry_out = data[0];
      end
      default:
      begin
        result = data;
      end
    endcase
  end

endmodule

// >>> rtl/cond_check.sv
`timescale 1ns/1ps
module cond_check
  import flag_eval_pkg::*;
(
  // condition and flags
  input  wire logic [3:0] cond,
  input  wire logic       neg,
  input  wire logic       zero,
  input  wire logic       carry,
  input  wire logic       ovf,
  // verdict
  output logic            pass
);

  always_comb
  begin
    case (cond)
      ZERO_SET_COND:           pass = zero;
      NONZERO_COND:            pass = ~zero;
      UNSIGNED_AT_LEAST_COND:  pass = carry;
      CARRY_LOW_COND:          pass = ~carry;
      SIGN_SET_COND:           pass = neg;
      SIGN_CLEAR_COND:         pass = ~neg;
      OVF_SET_COND:            pass = ovf;
      OVF_CLEAR_COND:          pass = ~ovf;
      UNSIGNED_ABOVE_COND:     pass = carry & ~zero;
      UNSIGNED_NOT_ABOVE_COND: pass = ~carry | zero;
      SIGNED_AT_LEAST_COND:    pass = (neg == ovf);
      SIGNED_UNDER_COND:       pass = (neg != ovf);
      SIGNED_ABOVE_COND:       pass = ~zero & (neg == ovf);
      SIGNED_AT_MOST_COND:     pass = zero | (neg != ovf);
      // the spare code is treated as always too, so it never blocks
      default:                 pass = 1'b1;
    endcase
  end

endmodule

// >>> rtl/cond_flag_eval_unit.sv
`timescale 1ns/1ps
// Summary of operation
// - loads and stores never touch the four status flags.
// - data operations keep flags unless the set-flags suffix is given.
// - compare and test always set flags; a set-flags suffix there is flagged.
// - compare, negated compare, test, equivalence do sub, add, and, xor; no destination.
// - the status write instruction loads the flags directly.
// - carry comes from the adder or from the shifter, by operation.
// - the shifter moves a word any distance within one cycle.
// - the prefix makes one to four followers conditional, base or inverse.
// - the prefix is a 16-bit word; mask bits pick then or else.
// - inside the block 16-bit data operations do not set flags; compares still do.
// - block progress lives in the status word and survives exceptions.
// - an instruction executes only if its condition holds on current flags.
// - zero-set, nonzero, carry-set and carry-clear test Z and C.
// - sign and overflow conditions test N and V.
// - unsigned above needs C set, Z clear; not-above is the inverse.
// - signed conditions compare N with V, greater adds Z clear.
// - no suffix means always, which passes unconditionally.
// - negative flag is bit 31 and copies result bit 31.
// - zero flag is bit 30 and is set when the result is zero.
// - carry flag is bit 29: adder carry or last bit shifted out.
// - carry reports unsigned overflow of the 32-bit result for chaining.
// - overflow flag is bit 28 and reports signed overflow into the sign.
module cond_flag_eval_unit
  import flag_eval_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst_b,
  // issued instruction
  input  wire logic               issue_valid,
  input  wire instr_class_t       instr_class,
  input  wire alu_op_t            alu_op,
  input  wire logic [3:0]         cond,
  input  wire logic               set_flags,
  input  wire logic               is_16bit,
  input  wire logic [WORD_W-1:0]  operand_a,
  input  wire logic [WORD_W-1:0]  operand_b,
  input  wire shift_kind_t        shift_kind,
  input  wire logic [SHAMT_W-1:0] shift_amount,
  input  wire logic [WORD_W-1:0]  status_wdata,
  input  wire logic [7:0]         prefix_code,
  // exception entry and return
  input  wire logic               exc_entry,
  input  wire logic               exc_return,
  // execution outcome
  output logic                    exec_valid,
  output logic                    exec_taken,
  output logic [WORD_W-1:0]       exec_result,
  output logic                    dest_write,
  output logic                    mem_access_go,
  output logic                    suffix_fault,
  // status words
  output logic [WORD_W-1:0]       current_status_word,
  output logic [WORD_W-1:0]       saved_status_word,
  output logic                    in_if_then
);

  typedef struct packed {
    logic [WORD_W-1:0] cur;
    logic [WORD_W-1:0] saved;
    logic [WORD_W-1:0] result;
    logic              exec_valid;
    logic              exec_taken;
    logic              dest_write;
    logic              mem_go;
    logic              suffix_fault;
    logic              in_ifthen;
  } unit_state_t;

  localparam unit_state_t STATE_RESET = '{
    cur:          STATUS_RESET,
    saved:        STATUS_RESET,
    result:       '0,
    exec_valid:   1'b0,
    exec_taken:   1'b0,
    dest_write:   1'b0,
    mem_go:       1'b0,
    suffix_fault: 1'b0,
    in_ifthen:    1'b0
  };

  unit_state_t       state_q;
  unit_state_t       state_d;

  logic [7:0]        ift_now;
  logic              ift_active;
  logic [3:0]        eff_cond;
  logic              cond_pass;
  logic [WORD_W-1:0] shifted;
  logic              shift_carry;

  logic [WORD_W-1:0] add_b;
  logic              add_cin;
  logic              is_arith;
  logic [WORD_W:0]   sum;
  logic              sum_ovf;
  logic [WORD_W-1:0] alu_res;
  logic [3:0]        alu_flags;
  logic [WORD_W-1:0] next_word;
  logic [7:0]        next_ift;

  // inside a block the slot condition replaces the instruction's own suffix
  assign ift_now    = read_ifthen(state_q.cur);
  assign ift_active = (ift_now[3:0] != 4'h0);
  assign eff_cond   = ift_active ? ift_now[7:4] : cond;

  cond_check u_cond_check (
    .cond  (eff_cond),
    .neg   (state_q.cur[NEG_BIT]),
    .zero  (state_q.cur[ZERO_BIT]),
    .carry (state_q.cur[CARRY_BIT]),
    .ovf   (state_q.cur[OVF_BIT]),
    .pass  (cond_pass)
  );

  barrel_shifter #(
    .W (WORD_W)
  ) u_barrel_shifter (
    .data      (operand_b),
    .kind      (shift_kind),
    .amount    (shift_amount),
    .carry_in  (state_q.cur[CARRY_BIT]),
    .result    (shifted),
    .carry_out (shift_carry)
  );

  // adder and logic unit; the second operand always passes the shifter
  always_comb
  begin
    add_b    = shifted;
    add_cin  = 1'b0;
    is_arith = 1'b1;
    case (alu_op)
      ALU_ADD:
      begin
        add_cin = 1'b0;
      end
      ALU_ADC:
      begin
        add_cin = state_q.cur[CARRY_BIT];
      end
      ALU_SUB:
      begin
        add_b   = ~shifted;
        add_cin = 1'b1;
      end
      ALU_SBC:
      begin
        add_b   = ~shifted;
        add_cin = state_q.cur[CARRY_BIT];
      end
      default:
      begin
        is_arith = 1'b0;
      end
    endcase
    sum     = {1'b0, operand_a} + {1'b0, add_b} + {{WORD_W{1'b0}}, add_cin};
    // signed overflow: like-signed inputs give a result of the other sign
    sum_ovf = (operand_a[WORD_W-1] == add_b[WORD_W-1]) && (sum[WORD_W-1] != operand_a[WORD_W-1]);
    case (alu_op)
      ALU_AND: alu_res = operand_a & shifted;
      ALU_EOR: alu_res = operand_a ^ shifted;
      ALU_ORR: alu_res = operand_a | shifted;
      ALU_BIC: alu_res = operand_a & ~shifted;
      ALU_MOV: alu_res = shifted;
      ALU_MVN: alu_res = ~shifted;
      default: alu_res = sum[WORD_W-1:0];
    endcase
    alu_flags[3] = alu_res[WORD_W-1];
    alu_flags[2] = (alu_res == '0);
    // logical operations take the shifter carry and keep overflow
    alu_flags[1] = is_arith ? sum[WORD_W] : shift_carry;
    alu_flags[0] = is_arith ? sum_ovf : state_q.cur[OVF_BIT];
  end

  always_comb
  begin
    state_d              = state_q;
    state_d.exec_valid   = 1'b0;
    state_d.exec_taken   = 1'b0;
    state_d.dest_write   = 1'b0;
    state_d.mem_go       = 1'b0;
    state_d.suffix_fault = 1'b0;
    next_word            = state_q.cur;
    next_ift             = ift_active ? advance_ifthen(ift_now) : IFT_IDLE;
    if (exc_entry)
    begin
      // the issue in this cycle is dropped; the handler starts outside any block
      state_d.saved = state_q.cur;
      state_d.cur   = write_ifthen(state_q.cur, IFT_IDLE);
    end
    else if (exc_return)
    begin
      state_d.cur = state_q.saved;
    end
    else if (issue_valid)
    begin
      state_d.exec_valid = 1'b1;
      state_d.exec_taken = cond_pass;
      if (cond_pass)
      begin
        case (instr_class)
          CLS_DATA:
          begin
            state_d.result     = alu_res;
            state_d.dest_write = 1'b1;
            if (set_flags && !(ift_active && is_16bit))
            begin
              next_word[FLAGS_LSB +: FLAGS_W] = alu_flags;
            end
          end
          CLS_COMPARE:
          begin
            // flags only, whatever the suffix or block state says
            next_word[FLAGS_LSB +: FLAGS_W] = alu_flags;
            state_d.suffix_fault            = set_flags;
          end
          CLS_MEMORY:
          begin
            state_d.mem_go = 1'b1;
          end
          CLS_STATUS_WRITE:
          begin
            next_word[FLAGS_LSB +: FLAGS_W] = status_wdata[FLAGS_LSB +: FLAGS_W];
          end
          CLS_IF_THEN:
          begin
            // a nested prefix or an empty mask is ignored
            if (!ift_active && (prefix_code[3:0] != 4'h0))
            begin
              next_ift = prefix_code;
            end
          end
          default:
          begin
            next_word = state_q.cur;
          end
        endcase
      end
      // a failed condition still consumes its slot but changes nothing else
      state_d.cur = write_ifthen(next_word, next_ift);
    end
    state_d.in_ifthen = (read_ifthen(state_d.cur) != IFT_IDLE);
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= STATE_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign exec_valid          = state_q.exec_valid;
  assign exec_taken          = state_q.exec_taken;
  assign exec_result         = state_q.result;
  assign dest_write          = state_q.dest_write;
  assign mem_access_go       = state_q.mem_go;
  assign suffix_fault        = state_q.suffix_fault;
  assign current_status_word = state_q.cur;
  assign saved_status_word   = state_q.saved;
  assign in_if_then          = state_q.in_ifthen;

endmodule

// >>> rtl/flag_eval_pkg.sv
package flag_eval_pkg;

  // word and status layout
  localparam int WORD_W     = 32;
  localparam int NEG_BIT    = 31;
  localparam int ZERO_BIT   = 30;
  localparam int CARRY_BIT  = 29;
  localparam int OVF_BIT    = 28;
  localparam int FLAGS_LSB  = 28;
  localparam int FLAGS_W    = 4;
  localparam int IFT_HI_LSB = 10;
  localparam int IFT_HI_W   = 6;
  localparam int IFT_LO_LSB = 25;
  localparam int IFT_LO_W   = 2;
  localparam int SHAMT_W    = 8;

  // reset values
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [7:0]  IFT_IDLE     = 8'h00;

  typedef enum logic [3:0] {
    ZERO_SET_COND           = 4'h0,
    NONZERO_COND            = 4'h1,
    UNSIGNED_AT_LEAST_COND  = 4'h2,
    CARRY_LOW_COND          = 4'h3,
    SIGN_SET_COND           = 4'h4,
    SIGN_CLEAR_COND         = 4'h5,
    OVF_SET_COND            = 4'h6,
    OVF_CLEAR_COND          = 4'h7,
    UNSIGNED_ABOVE_COND     = 4'h8,
    UNSIGNED_NOT_ABOVE_COND = 4'h9,
    SIGNED_AT_LEAST_COND    = 4'ha,
    SIGNED_UNDER_COND       = 4'hb,
    SIGNED_ABOVE_COND       = 4'hc,
    SIGNED_AT_MOST_COND     = 4'hd,
    NO_CONDITION            = 4'he
  } cond_t;

  typedef enum logic [2:0] {
    CLS_DATA         = 3'h0,
    CLS_COMPARE      = 3'h1,
    CLS_MEMORY       = 3'h2,
    CLS_STATUS_WRITE = 3'h3,
    CLS_IF_THEN      = 3'h4,
    CLS_OTHER        = 3'h5
  } instr_class_t;

  typedef enum logic [3:0] {
    ALU_ADD = 4'h0,
    ALU_ADC = 4'h1,
    ALU_SUB = 4'h2,
    ALU_SBC = 4'h3,
    ALU_AND = 4'h4,
    ALU_EOR = 4'h5,
    ALU_ORR = 4'h6,
    ALU_BIC = 4'h7,
    ALU_MOV = 4'h8,
    ALU_MVN = 4'h9
  } alu_op_t;

  typedef enum logic [2:0] {
    SHIFT_LEFT        = 3'h0,
    SHIFT_RIGHT_LOGIC = 3'h1,
    SHIFT_RIGHT_ARITH = 3'h2,
    SHIFT_ROTATE      = 3'h3,
    SHIFT_ROTATE_EXT  = 3'h4
  } shift_kind_t;

  function automatic logic [7:0] read_ifthen(input logic [31:0] w);
    return {w[IFT_HI_LSB +: IFT_HI_W], w[IFT_LO_LSB +: IFT_LO_W]};
  endfunction

  function automatic logic [31:0] write_ifthen(input logic [31:0] w, input logic [7:0] s);
    logic [31:0] r;
    r = w;
    r[IFT_HI_LSB +: IFT_HI_W] = s[7:2];
    r[IFT_LO_LSB +: IFT_LO_W] = s[1:0];
    return r;
  endfunction

  // last slot consumed clears the state; otherwise shift the slot markers up
  function automatic logic [7:0] advance_ifthen(input logic [7:0] s);
    if (s[2:0] == 3'h0)
    begin
      return IFT_IDLE;
    end
    return {s[7:5], s[3:0], 1'b0};
  endfunction

endpackage

// >>> verif/core_issue_model.sv
`timescale 1ns/1ps
module core_issue_model
  import flag_eval_pkg::*;
(
  // clock
  input  wire logic               core_clk,
  // issue side
  output logic                    issue_valid,
  output instr_class_t            instr_class,
  output alu_op_t                 alu_op,
  output logic [3:0]              cond,
  output logic                    set_flags,
  output logic                    is_16bit,
  output logic [WORD_W-1:0]       operand_a,
  output logic [WORD_W-1:0]       operand_b,
  output shift_kind_t             shift_kind,
  output logic [SHAMT_W-1:0]      shift_amount,
  output logic [WORD_W-1:0]       status_wdata,
  output logic [7:0]              prefix_code,
  // exceptions
  output logic                    exc_entry,
  output logic                    exc_return
);
  initial
  begin
    issue_valid = 1'b0;
    exc_entry = 1'b0;
    exc_return = 1'b0;
    instr_class = CLS_OTHER;
    alu_op = ALU_ADD;
    cond = 4'he;
    set_flags = 1'b0;
    is_16bit = 1'b0;
    operand_a = 32'h0;
    operand_b = 32'h0;
    shift_kind = SHIFT_LEFT;
    shift_amount = 8'h00;
    status_wdata = 32'h0;
    prefix_code = 8'h00;
  end

  task automatic shift(input shift_kind_t k, input logic [7:0] n);
    shift_kind = k;
    shift_amount = n;
  endtask

  // a doubles as status word and prefix byte; operands flip once released
  task automatic issue(input instr_class_t c, input alu_op_t o, input logic [3:0] cd,
                       input logic s, h, input logic [31:0] a, b);
    @(negedge core_clk);
    issue_valid = 1'b1;
    instr_class = c;
    alu_op = o;
    cond = cd;
    set_flags = s;
    is_16bit = h;
    operand_a = a;
    operand_b = b;
    status_wdata = a;
    prefix_code = a[7:0];
    @(negedge core_clk);
    issue_valid = 1'b0;
    operand_a = ~a;
    operand_b = ~b;
    status_wdata = ~a;
    prefix_code = ~a[7:0];
  endtask

  task automatic exc(input logic e, r);
    @(negedge core_clk);
    exc_entry = e;
    exc_return = r;
    @(negedge core_clk);
    exc_entry = 1'b0;
    exc_return = 1'b0;
  endtask
endmodule

// >>> verif/flag_eval_checker.sv
`timescale 1ns/1ps
module flag_eval_checker
  import flag_eval_pkg::*;
(
  // clock and reset
  input wire logic               core_clk,
  input wire logic               rst_b,
  // issue
  input wire logic               issue_valid,
  input wire instr_class_t       instr_class,
  input wire alu_op_t            alu_op,
  input wire logic [3:0]         cond,
  input wire logic               set_flags,
  input wire logic [WORD_W-1:0]  operand_a,
  input wire logic [WORD_W-1:0]  operand_b,
  input wire shift_kind_t        shift_kind,
  input wire logic [SHAMT_W-1:0] shift_amount,
  input wire logic [WORD_W-1:0]  status_wdata,
  input wire logic               exc_entry,
  input wire logic               exc_return,
  // outcome
  input wire logic               exec_valid,
  input wire logic               exec_taken,
  input wire logic               dest_write,
  input wire logic               mem_access_go,
  input wire logic               suffix_fault,
  input wire logic [WORD_W-1:0]  current_status_word,
  input wire logic [WORD_W-1:0]  saved_status_word,
  input wire logic               in_if_then
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  logic [3:0] flg;
  logic [3:0] wflg;
  logic       plain;

  assign flg = current_status_word[FLAGS_LSB +: FLAGS_W];
  assign wflg = status_wdata[FLAGS_LSB +: FLAGS_W];
  // outside a block with no suffix the condition cannot fail
  assign plain = cond == NO_CONDITION && !in_if_then;

  sequence s_take;
    issue_valid && !exc_entry && !exc_return;
  endsequence
  sequence s_cls(instr_class_t c);
    s_take ##0 instr_class == c;
  endsequence

  a_issue_answer: assert property (s_take |=> exec_valid)
    else $error("issue not answered");
  a_mem_flags: assert property (s_cls(CLS_MEMORY) |=> $stable(flg))
    else $error("memory op changed flags");
  a_data_keep: assert property (s_cls(CLS_DATA) ##0 !set_flags |=> $stable(flg))
    else $error("data op without suffix changed flags");
  a_fail_inert: assert property (exec_valid && !exec_taken |-> !dest_write && !mem_access_go && $stable(flg))
    else $error("failed condition had an effect");
  a_status_load: assert property (s_cls(CLS_STATUS_WRITE) ##0 plain |=> flg == $past(wflg))
    else $error("status write did not load flags");
  a_cmp_equal: assert property (s_cls(CLS_COMPARE) ##0 (alu_op == ALU_SUB && operand_a == operand_b && plain
    && shift_amount == 8'h00 && shift_kind != SHIFT_ROTATE_EXT) |=> flg[2:1] == 2'b11)
    else $error("equal compare did not set zero and carry");
  a_suffix_fault: assert property (s_cls(CLS_COMPARE) ##0 (set_flags && plain) |=> suffix_fault)
    else $error("suffix on compare not reported");
  a_exc_save: assert property (exc_entry |=> saved_status_word == $past(current_status_word) && !in_if_then)
    else $error("exception entry did not save status");
  a_exc_resume: assert property (exc_return && !exc_entry |=> current_status_word == $past(saved_status_word))
    else $error("exception return did not restore status");
endmodule

bind cond_flag_eval_unit flag_eval_checker u_chk (.*);

// >>> verif/tb_cond_flag_eval_unit.sv
`timescale 1ns/1ps
module tb_cond_flag_eval_unit;
  import flag_eval_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         issue_valid, set_flags, is_16bit, exc_entry, exc_return;
  instr_class_t instr_class;
  alu_op_t      alu_op;
  shift_kind_t  shift_kind;
  logic [3:0]   cond, flg;
  logic [7:0]   shift_amount, prefix_code;
  logic [31:0]  operand_a, operand_b, status_wdata, exec_result, current_status_word, saved_status_word;
  logic         exec_valid, exec_taken, dest_write, mem_access_go, suffix_fault, in_if_then;
  int           bad_count = 0;
  int           comparisons = 0;

  assign flg = current_status_word[31:28];
  always #50 core_clk = ~core_clk;

  core_issue_model u_core (.*);
  cond_flag_eval_unit u_dut (.*);

  task automatic chk(input string w, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chkf(input string w, input logic [3:0] e);
    chk(w, {28'h0, e}, {28'h0, flg});
  endtask
  task automatic chkb(input string w, input logic e, g);
    chk(w, {31'h0, e}, {31'h0, g});
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic want(input logic [3:0] c, f);
    logic n, z, k, v;
    {n, z, k, v} = f;
    case (c)
      4'h0: return z;
      4'h1: return !z;
      4'h2: return k;
      4'h3: return !k;
      4'h4: return n;
      4'h5: return !n;
      4'h6: return v;
      4'h7: return !v;
      4'h8: return k && !z;
      4'h9: return !k || z;
      4'ha: return n == v;
      4'hb: return n != v;
      4'hc: return !z && n == v;
      4'hd: return z || n != v;
      default: return 1'b1;
    endcase
  endfunction

  task automatic setf(input logic [3:0] f);
    u_core.issue(CLS_STATUS_WRITE, ALU_ADD, 4'he, 1'b0, 1'b0, {f, 28'h0}, 32'h0);
    chkf("status write", f);
  endtask

  task automatic cmp(input alu_op_t o, input logic [31:0] a, b, input logic [3:0] f);
    u_core.issue(CLS_COMPARE, o, 4'he, 1'b0, 1'b0, a, b);
    chkb("cmp valid", 1'b1, exec_valid);
    chkb("cmp dest", 1'b0, dest_write);
    chkf("cmp flags", f);
  endtask

  task automatic t_compare;
    cmp(ALU_SUB, 32'h5, 32'h5, 4'h6);
    cmp(ALU_SUB, 32'h1, 32'h2, 4'h8);
    cmp(ALU_ADD, 32'h7fffffff, 32'h1, 4'h9);
    cmp(ALU_ADD, 32'hffffffff, 32'h1, 4'h6);
    cmp(ALU_AND, 32'h80000000, 32'hffffffff, 4'ha);
    cmp(ALU_EOR, 32'h3, 32'h3, 4'h6);
    u_core.issue(CLS_COMPARE, ALU_SUB, 4'he, 1'b1, 1'b0, 32'h9, 32'h9);
    chkb("suffix", 1'b1, suffix_fault);
    $display("test compare done");
  endtask

  task automatic t_data;
    u_core.issue(CLS_DATA, ALU_ADD, 4'he, 1'b0, 1'b0, 32'h7fffffff, 32'h1);
    chk("add result", 32'h80000000, exec_result);
    chkb("add dest", 1'b1, dest_write);
    chkf("add keeps", 4'h6);
    u_core.issue(CLS_DATA, ALU_ADD, 4'he, 1'b1, 1'b0, 32'hffffffff, 32'hffffffff);
    chkf("adds flags", 4'ha);
    u_core.issue(CLS_DATA, ALU_ADC, 4'he, 1'b1, 1'b0, 32'h1, 32'h1);
    chk("adc result", 32'h3, exec_result);
    chkf("adc flags", 4'h0);
    setf(4'hb);
    u_core.issue(CLS_MEMORY, ALU_ADD, 4'he, 1'b1, 1'b0, 32'h0, 32'h0);
    chkb("mem go", 1'b1, mem_access_go);
    chkf("mem flags", 4'hb);
    u_core.issue(CLS_MEMORY, ALU_ADD, 4'h0, 1'b0, 1'b0, 32'h0, 32'h0);
    chkb("mem blocked", 1'b0, mem_access_go);
    chkb("mem not taken", 1'b0, exec_taken);
    $display("test data done");
  endtask

  task automatic t_cond;
    for (int f = 0; f < 16; f++)
      for (int c = 0; c < 16; c++)
      begin
        setf(f[3:0]);
        u_core.issue(CLS_DATA, ALU_MOV, c[3:0], 1'b0, 1'b0, 32'h0, 32'h55);
        chkb("taken", want(c[3:0], f[3:0]), exec_taken);
        chkb("write", want(c[3:0], f[3:0]), dest_write);
      end
    $display("test cond done");
  endtask

  task automatic sh(input shift_kind_t k, input logic [7:0] n, input logic [31:0] b, r, input logic [3:0] f);
    u_core.shift(k, n);
    u_core.issue(CLS_DATA, ALU_MOV, 4'he, 1'b1, 1'b0, 32'h0, b);
    chk("shift result", r, exec_result);
    chkf("shift flags", f);
  endtask

  task automatic t_shift;
    setf(4'h0);
    sh(SHIFT_LEFT, 8'h04, 32'h10000001, 32'h00000010, 4'h2);
    sh(SHIFT_RIGHT_LOGIC, 8'h01, 32'h3, 32'h1, 4'h2);
    sh(SHIFT_RIGHT_ARITH, 8'h04, 32'h80000000, 32'hf8000000, 4'h8);
    sh(SHIFT_ROTATE, 8'h08, 32'h000000ff, 32'hff000000, 4'ha);
    sh(SHIFT_ROTATE_EXT, 8'h00, 32'h00000002, 32'h80000001, 4'h8);
    u_core.shift(SHIFT_LEFT, 8'h00);
    u_core.issue(CLS_DATA, ALU_SBC, 4'he, 1'b1, 1'b0, 32'h5, 32'h3);
    chk("sbc result", 32'h1, exec_result);
    chkf("sbc flags", 4'h2);
    $display("test shift done");
  endtask

  task automatic t_block;
    setf(4'h4);
    u_core.issue(CLS_IF_THEN, ALU_ADD, 4'he, 1'b0, 1'b1, 32'h0c, 32'h0);
    chkb("in block", 1'b1, in_if_then);
    u_core.issue(CLS_DATA, ALU_MOV, 4'he, 1'b1, 1'b1, 32'h0, 32'h80000000);
    chkb("then taken", 1'b1, exec_taken);
    chkf("no set inside", 4'h4);
    u_core.issue(CLS_DATA, ALU_MOV, 4'he, 1'b0, 1'b1, 32'h0, 32'h1);
    chkb("else skipped", 1'b0, exec_taken);
    chkb("block over", 1'b0, in_if_then);
    u_core.issue(CLS_IF_THEN, ALU_ADD, 4'he, 1'b0, 1'b1, 32'h0c, 32'h0);
    u_core.exc(1'b1, 1'b0);
    chk("saved", 32'h40000c00, saved_status_word);
    chk("entered", 32'h40000000, current_status_word);
    u_core.exc(1'b0, 1'b1);
    chk("resumed", 32'h40000c00, current_status_word);
    u_core.issue(CLS_COMPARE, ALU_SUB, 4'he, 1'b0, 1'b1, 32'h1, 32'h2);
    chkf("cmp inside", 4'h8);
    u_core.issue(CLS_DATA, ALU_MOV, 4'he, 1'b0, 1'b1, 32'h0, 32'h7);
    chkb("else taken", 1'b1, dest_write);
    chk("else result", 32'h7, exec_result);
    $display("test block done");
  endtask

  initial
  begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    chk("reset status", 32'h0, current_status_word);
    chkb("reset valid", 1'b0, exec_valid);
    $display("test reset done");
    rst_b = 1'b1;
    t_compare;
    t_data;
    t_cond;
    t_shift;
    t_block;
    results;
  end

  // the tests need about 1,100 cycles
  initial
  begin
    #500000;
    bad_count++;
    results;
  end
endmodule
